// File: verilog/quadrature_wheel_decoder.sv
/*
 * Wheel quadrature decoder with APB register access.
 * Assumes: PIN_IN comes from pads outside the SYS_CLK domain; APB master
 * on SYS_CLK; a 32 kHz step rate is derived here from SYS_CLK.
 */
`timescale 1ns/100ps
`default_nettype none

module quadrature_wheel_decoder
    import qw_pkg::*;
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [`QW_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]           PWDATA,
    input  wire logic [3:0]            PSTRB,
    output var  logic [31:0]           PRDATA,
    output var  logic                  PREADY,
    output var  logic                  PSLVERR,
    input  wire logic [7:0]            PIN_IN
);

    function automatic logic addr_is(input logic [`QW_ADDR_W-1:0] a,
                                     input logic [`QW_IDX_W-1:0]  idx);
        addr_is = (a == {idx, 2'b00});
    endfunction : addr_is

    cfg_t                 cfg_q;
    logic [7:0]           pin_s1_q;
    logic [7:0]           pin_s2_q;
    logic                 a_raw_q;
    logic                 b_raw_q;
    logic [`QW_DIV_W-1:0] div_q;
    logic                 tick_q;
    logic                 a_clean;
    logic                 b_clean;
    logic                 a_prev_q;
    logic                 b_prev_q;
    step_t                step;
    logic [7:0]           count_q;
    logic [7:0]           snap_q;
    logic                 load_q;
    logic                 setup;
    logic                 acc;
    logic                 wr;
    logic                 rd_snap;
    logic                 wr_load;
    logic                 hit;
    logic [31:0]          rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // pad synchronisers and phase pin selection
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end
        else
        begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    // PIN_IN order: A2,A3,B6,B7,C2,C3,D6,D7; pola inverts idle-high inputs
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            a_raw_q <= 1'b0;
            b_raw_q <= 1'b0;
        end
        else
        begin
            a_raw_q <= pin_s2_q[cfg_q.sel_a] ^ cfg_q.pola;
            b_raw_q <= pin_s2_q[cfg_q.sel_b] ^ cfg_q.pola;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow step tick
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == `QW_DIV_W'(`QW_SLOW_DIV - 1));
            if (div_q == `QW_DIV_W'(`QW_SLOW_DIV - 1))
                div_q <= '0;
            else
                div_q <= div_q + `QW_DIV_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debounce
    phase_debouncer u_deb_a (
        .clk     (SYS_CLK),
        .rst     (RST),
        .tick    (tick_q),
        .filt    (cfg_q.filt),
        .raw     (a_raw_q),
        .clean_q (a_clean)
    );

    phase_debouncer u_deb_b (
        .clk     (SYS_CLK),
        .rst     (RST),
        .tick    (tick_q),
        .filt    (cfg_q.filt),
        .raw     (b_raw_q),
        .clean_q (b_clean)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge decode
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end
        else
        begin
            a_prev_q <= a_clean;
            b_prev_q <= b_clean;
        end
    end

    // both phases moving at once carries no direction: ignored
    always_comb
    begin
        step = STEP_NONE;
        if ((a_clean != a_prev_q) ^ (b_clean != b_prev_q))
        begin
            if (cfg_q.double_mode)
            begin
                if (a_clean != a_prev_q)
                    step = (a_clean != b_clean) ? STEP_UP : STEP_DOWN;
                else
                    step = (a_clean == b_clean) ? STEP_UP : STEP_DOWN;
            end
            else if (a_clean == b_clean)
                step = (b_clean != b_prev_q) ? STEP_UP : STEP_DOWN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live counter, hidden from the bus
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            count_q <= `QW_RST_COUNT;
        else if (cfg_q.dec_rst)
            count_q <= 8'h00;
        else
        begin
            case (step)
                STEP_UP:   count_q <= count_q + 8'h01;
                STEP_DOWN: count_q <= count_q - 8'h01;
                STEP_NONE: count_q <= count_q;
                default:   count_q <= count_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup   = PSEL & ~PENABLE;
    assign acc     = PSEL & PENABLE & PREADY;
    assign wr      = acc & PWRITE & PSTRB[0];
    assign rd_snap = acc & ~PWRITE & addr_is(PADDR, `QW_IDX_SNAPSHOT);
    assign wr_load = wr & addr_is(PADDR, `QW_IDX_LOAD) & PWDATA[0];
    assign hit     = addr_is(PADDR, `QW_IDX_RESET) | addr_is(PADDR, `QW_IDX_SNAPSHOT)
                   | addr_is(PADDR, `QW_IDX_FILTER) | addr_is(PADDR, `QW_IDX_SEL_A)
                   | addr_is(PADDR, `QW_IDX_SEL_B) | addr_is(PADDR, `QW_IDX_MODE)
                   | addr_is(PADDR, `QW_IDX_LOAD);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (addr_is(PADDR, `QW_IDX_RESET))
            rd_mux[`QW_BIT_DEC_RST] = cfg_q.dec_rst;
        else if (addr_is(PADDR, `QW_IDX_SNAPSHOT))
            rd_mux[7:0] = snap_q;
        else if (addr_is(PADDR, `QW_IDX_FILTER))
        begin
            rd_mux[2:0]              = cfg_q.filt;
            rd_mux[`QW_BIT_POLA]     = cfg_q.pola;
            rd_mux[`QW_BIT_SHUTTLE]  = cfg_q.shuttle;
        end
        else if (addr_is(PADDR, `QW_IDX_SEL_A))
            rd_mux[2:0] = cfg_q.sel_a;
        else if (addr_is(PADDR, `QW_IDX_SEL_B))
            rd_mux[2:0] = cfg_q.sel_b;
        else if (addr_is(PADDR, `QW_IDX_MODE))
            rd_mux[0] = cfg_q.double_mode;
        else if (addr_is(PADDR, `QW_IDX_LOAD))
            rd_mux[0] = load_q;
    end

    // answer registered in setup, so access phase always completes in one cycle
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= setup;
            PSLVERR <= setup & ~hit;
            PRDATA  <= (setup & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            cfg_q.dec_rst     <= `QW_RST_DEC_RST;
            cfg_q.filt        <= `QW_RST_FILT;
            cfg_q.pola        <= `QW_RST_POLA;
            cfg_q.shuttle     <= `QW_RST_SHUTTLE;
            cfg_q.sel_a       <= `QW_RST_SEL_A;
            cfg_q.sel_b       <= `QW_RST_SEL_B;
            cfg_q.double_mode <= `QW_RST_MODE;
        end
        else if (wr)
        begin
            if (addr_is(PADDR, `QW_IDX_RESET))
                cfg_q.dec_rst <= PWDATA[`QW_BIT_DEC_RST];
            if (addr_is(PADDR, `QW_IDX_FILTER))
            begin
                cfg_q.filt    <= PWDATA[2:0];
                cfg_q.pola    <= PWDATA[`QW_BIT_POLA];
                cfg_q.shuttle <= PWDATA[`QW_BIT_SHUTTLE];
            end
            if (addr_is(PADDR, `QW_IDX_SEL_A))
                cfg_q.sel_a <= PWDATA[2:0];
            if (addr_is(PADDR, `QW_IDX_SEL_B))
                cfg_q.sel_b <= PWDATA[2:0];
            if (addr_is(PADDR, `QW_IDX_MODE))
                cfg_q.double_mode <= PWDATA[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // load strobe and snapshot
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            load_q <= 1'b0;
        else
            load_q <= wr_load;
    end

    // load wins over read-clear
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            snap_q <= `QW_RST_COUNT;
        else if (load_q)
            snap_q <= count_q;
        else if (rd_snap)
            snap_q <= 8'h00;
        else
            snap_q <= snap_q;
    end

    ////////////////////////////////////////////////////////////////////////
    pin_route_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        $stable(cfg_q) |=> a_raw_q == $past(pin_s2_q[cfg_q.sel_a] ^ cfg_q.pola)
                           && b_raw_q == $past(pin_s2_q[cfg_q.sel_b] ^ cfg_q.pola))
        else $error("phase input not routed from selected pin");

    slow_tick_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        tick_q |-> $past(div_q) == `QW_DIV_W'(`QW_SLOW_DIV - 1) ##1 !tick_q)
        else $error("slow tick out of period");

    snap_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !load_q && !rd_snap |=> $stable(snap_q))
        else $error("snapshot moved without load or read");

    load_copy_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        wr_load |=> load_q ##1 snap_q == $past(count_q))
        else $error("load did not copy live counter");

    load_self_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        load_q && !wr_load |=> !load_q)
        else $error("load bit did not return to zero");

    read_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        rd_snap && !load_q |=> snap_q == 8'h00)
        else $error("snapshot not cleared after read");

    dec_reset_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        cfg_q.dec_rst |=> count_q == 8'h00)
        else $error("decoder reset did not clear counter");

    double_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        cfg_q.double_mode && !cfg_q.dec_rst
        && ((a_clean != a_prev_q) ^ (b_clean != b_prev_q))
        |=> (count_q - $past(count_q) == 8'h01) || ($past(count_q) - count_q == 8'h01))
        else $error("double mode edge did not move counter by one");

    common_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !cfg_q.double_mode && (a_clean != b_clean) |=> $stable(count_q) || $past(cfg_q.dec_rst))
        else $error("common mode counted on mismatched phases");

    lead_dir_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !cfg_q.dec_rst && (b_clean != b_prev_q) && (a_clean == a_prev_q)
        && (a_clean == b_clean) |=> count_q == $past(count_q) + 8'h01)
        else $error("phase a leading did not count up");

    apb_answer_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup |=> PREADY ##1 !PREADY || setup)
        else $error("apb answer not one cycle after setup");

endmodule : quadrature_wheel_decoder

`default_nettype wire

// File: verilog/qw_cfg.svh
/*
 * Constants of the wheel quadrature decoder: register indices, field
 * positions, reset values and timing counts.
 * Assumes: included by bare name; byte address of a register is 4 * index.
 */
`ifndef QW_CFG_SVH
`define QW_CFG_SVH

// clocking
`define QW_SYS_CLK_HZ   100000000
`define QW_SLOW_CLK_HZ  32000
`define QW_SLOW_DIV     (`QW_SYS_CLK_HZ / `QW_SLOW_CLK_HZ)
`define QW_DIV_W        12

// debounce window = base * 2^(n+1) slow ticks
`define QW_WIN_BASE     3
`define QW_WIN_W        10

// bus
`define QW_ADDR_W       12
`define QW_IDX_W        10

// register indices
`define QW_IDX_RESET    10'h060
`define QW_IDX_SNAPSHOT 10'h0D0
`define QW_IDX_FILTER   10'h0D1
`define QW_IDX_SEL_A    10'h0D2
`define QW_IDX_SEL_B    10'h0D3
`define QW_IDX_MODE     10'h0D7
`define QW_IDX_LOAD     10'h0D8

// field positions
`define QW_BIT_DEC_RST  5
`define QW_BIT_POLA     4
`define QW_BIT_SHUTTLE  5

// reset values
`define QW_RST_RESET    8'h00
`define QW_RST_FILTER   8'h00
`define QW_RST_SEL_A    3'h0
`define QW_RST_SEL_B    3'h1
`define QW_RST_MODE     1'h1
`define QW_RST_COUNT    8'h00
`define QW_RST_DEC_RST  1'h0
`define QW_RST_FILT     3'h0
`define QW_RST_POLA     1'h0
`define QW_RST_SHUTTLE  1'h0

`endif

// File: verilog/qw_pkg.sv
/*
 * Types of the wheel quadrature decoder.
 * Assumes: qw_cfg.svh is on the include path.
 */
`include "qw_cfg.svh"

package qw_pkg;

    typedef struct packed {
        logic [2:0] filt;
        logic       pola;
        logic       shuttle;
        logic [2:0] sel_a;
        logic [2:0] sel_b;
        logic       double_mode;
        logic       dec_rst;
    } cfg_t;

    typedef enum logic [1:0] {STEP_NONE, STEP_UP, STEP_DOWN} step_t;

    function automatic logic [`QW_WIN_W-1:0] window_ticks(input logic [2:0] n);
        window_ticks = `QW_WIN_W'(`QW_WIN_BASE) << (n + 4'h1);
    endfunction : window_ticks

endpackage : qw_pkg

// File: verilog/phase_debouncer.sv
/*
 * Debounce filter for one phase input, stepped by the slow tick.
 * Assumes: raw is already synchronised to clk; tick is one cycle wide.
 */
`timescale 1ns/100ps
`default_nettype none

module phase_debouncer
    import qw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic [2:0] filt,
    input  wire logic       raw,
    output var  logic       clean_q
);

    logic [`QW_WIN_W-1:0] cnt_q;
    logic [`QW_WIN_W-1:0] th;

    assign th = window_ticks(filt);

    ////////////////////////////////////////////////////////////////////////
    // new level must hold for the whole window before it is taken
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q   <= '0;
            clean_q <= 1'b0;
        end
        else if (tick)
        begin
            if (raw == clean_q)
                cnt_q <= '0;
            else if (cnt_q == th - `QW_WIN_W'(1))
            begin
                clean_q <= raw;
                cnt_q   <= '0;
            end
            else
                cnt_q <= cnt_q + `QW_WIN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    debounce_window_a: assert property (@(posedge clk) disable iff (rst)
        $changed(clean_q) |-> $past(tick) && ($past(cnt_q) == $past(th) - `QW_WIN_W'(1)))
        else $error("phase level taken before window elapsed");

    debounce_stable_a: assert property (@(posedge clk) disable iff (rst)
        tick && (raw == clean_q) |=> cnt_q == '0)
        else $error("debounce count not cleared on matching level");

endmodule : phase_debouncer

`default_nettype wire

// File: test/wheel_encoder_model.sv
/*
 * Wheel encoder stand-in: puts two phase levels onto the selected pads.
 * Assumes: phase levels and pad choice come from the bench; pads that
 * are not selected carry a changing pattern.
 */
`timescale 1ns/100ps
`default_nettype none

module wheel_encoder_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] sel_a,
    input  wire logic [2:0] sel_b,
    input  wire logic       phase_a,
    input  wire logic       phase_b,
    output var  logic [7:0] pins
);
    logic [7:0] noise_q;

    ////////////////////////////////////////////////////////////////////////////
    // idle pads toggle so a wrong pick shows up in the count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            noise_q <= 8'hA5;
        else
            noise_q <= {noise_q[6:0], noise_q[7] ^ noise_q[5] ^ noise_q[4] ^ noise_q[3]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // pads are inputs only, never driven back by the decoder side
    always_comb
    begin
        pins        = noise_q;
        pins[sel_a] = phase_a;
        pins[sel_b] = phase_b;
    end
endmodule : wheel_encoder_model

`default_nettype wire

// File: test/quadrature_wheel_decoder_test.sv
/*
 * Self-checking bench of the wheel quadrature decoder.
 * Assumes: wheel_encoder_model drives the pads; APB answers wait-free.
 */
`timescale 1ns/100ps
`default_nettype none
`include "qw_cfg.svh"

module quadrature_wheel_decoder_test
    import qw_pkg::*;
;
    localparam int TICK  = 3125;
    localparam int WATCH = 32 * TICK;

    logic                  clk         = 1'b0;
    logic                  rst         = 1'b1;
    logic                  psel        = 1'b0;
    logic                  penable     = 1'b0;
    logic                  pwrite      = 1'b0;
    logic [`QW_ADDR_W-1:0] paddr       = '0;
    logic [31:0]           pwdata      = '0;
    logic [3:0]            pstrb       = '0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [7:0]            pin_in;
    logic                  ph_a        = 1'b0;
    logic                  ph_b        = 1'b0;
    logic [2:0]            sel_a_pin   = 3'h0;
    logic [2:0]            sel_b_pin   = 3'h1;
    logic                  cur_a       = 1'b0;
    logic                  cur_b       = 1'b0;
    logic                  dbl         = 1'b1;
    logic                  pol         = 1'b0;
    logic [7:0]            exp_cnt     = 8'h00;
    logic [7:0]            seed        = 8'h5B;
    logic [31:0]           rdat;
    logic                  rerr;
    int                    err_total   = 0;
    int                    check_count = 0;

    always #5 clk = ~clk;

    quadrature_wheel_decoder u_dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in));

    wheel_encoder_model u_wheel (.clk(clk), .rst(rst), .sel_a(sel_a_pin), .sel_b(sel_b_pin),
        .phase_a(ph_a), .phase_b(ph_b), .pins(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // count change for one phase edge
    function automatic logic [7:0] delta(input logic d, a0, b0, a1, b1);
        logic up;
        up = (a1 != a0) ? (a1 != b1) : (b1 == a1);
        if (!d && a1 != b1)
            return 8'h00;
        return up ? 8'h01 : 8'hFF;
    endfunction : delta

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        check("pready wait", n, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        check(nm, rdat, exp);
    endtask : rd_chk

    task step_to(input logic na, input logic nb);
        exp_cnt = exp_cnt + delta(dbl, cur_a, cur_b, na, nb);
        @(posedge clk);
        ph_a  <= na ^ pol;
        ph_b  <= nb ^ pol;
        cur_a = na;
        cur_b = nb;
        repeat (7 * TICK / 2) @(posedge clk);
    endtask : step_to

    task final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk("reset reg", 12'h180, 32'h0);
        rd_chk("snapshot", 12'h340, 32'h0);
        rd_chk("filter", 12'h344, 32'h0);
        rd_chk("sel_a", 12'h348, 32'h0);
        rd_chk("sel_b", 12'h34C, 32'h1);
        rd_chk("mode", 12'h35C, 32'h1);
        rd_chk("load", 12'h360, 32'h0);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        check("unmapped err", {31'h0, rerr}, 32'h1);
        check("unmapped data", rdat, 32'h0);
        apb(1'b1, 12'h348, 32'hFFFFFFFF, 4'hE);
        rd_chk("sel_a strobe", 12'h348, 32'h0);
        apb(1'b1, 12'h348, 32'hFFFFFFFF, 4'hF);
        rd_chk("sel_a field", 12'h348, 32'h7);
        $display("test registers done");
        seed = lfsr(seed);
        sel_a_pin = seed[2:0];
        seed = lfsr(seed);
        sel_b_pin = sel_a_pin + 3'(8'h01 + seed % 8'h07);
        apb(1'b1, 12'h348, {29'h0, sel_a_pin}, 4'hF);
        apb(1'b1, 12'h34C, {29'h0, sel_b_pin}, 4'hF);
        // short pulse on phase a, then three forward edges
        @(posedge clk);
        ph_a <= 1'b1;
        repeat (2 * TICK) @(posedge clk);
        ph_a <= 1'b0;
        repeat (TICK) @(posedge clk);
        step_to(1'b1, 1'b0);
        step_to(1'b1, 1'b1);
        step_to(1'b0, 1'b1);
        repeat (3 * TICK) @(posedge clk);
        rd_chk("snapshot held", 12'h340, 32'h0);
        apb(1'b1, 12'h360, 32'h1, 4'hF);
        rd_chk("load self clear", 12'h360, 32'h0);
        rd_chk("double count", 12'h340, {24'h0, exp_cnt});
        rd_chk("read clears", 12'h340, 32'h0);
        $display("test double done");
        apb(1'b1, 12'h344, 32'h37, 4'hF);
        rd_chk("filter fields", 12'h344, 32'h37);
        apb(1'b1, 12'h344, 32'h30, 4'hF);
        rd_chk("filter pola", 12'h344, 32'h30);
        // idle-high pads from here on: pads carry the inverse of the phase
        pol = 1'b1;
        @(posedge clk);
        ph_a <= ~cur_a;
        ph_b <= ~cur_b;
        apb(1'b1, 12'h35C, 32'h0, 4'hF);
        dbl = 1'b0;
        step_to(1'b1, 1'b1);
        step_to(1'b1, 1'b0);
        step_to(1'b0, 1'b0);
        repeat (3 * TICK) @(posedge clk);
        apb(1'b1, 12'h360, 32'h1, 4'hF);
        rd_chk("common count", 12'h340, {24'h0, exp_cnt});
        $display("test common done");
        apb(1'b1, 12'h180, 32'h20, 4'hF);
        rd_chk("reset bit", 12'h180, 32'h20);
        apb(1'b1, 12'h360, 32'h1, 4'hF);
        rd_chk("cleared count", 12'h340, 32'h0);
        apb(1'b1, 12'h180, 32'h0, 4'hF);
        $display("test decoder reset done");
        final_report();
    end

    initial
    begin
        repeat (WATCH) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule : quadrature_wheel_decoder_test

`default_nettype wire
